// >>> src/sdw_pkg.sv
// Constants, states and build variants of the SMBus DAC write slave.
// Assumes one core clock domain plus the serial clock from the bus.
package sdw_pkg;
  localparam int          CODE_W      = 10;
  localparam logic [3:0]  PREFIX_STD  = 4'h4;
  localparam logic [3:0]  PREFIX_ALT  = 4'h3;
  localparam logic [6:0]  ADDR_SOT_A  = 7'h20;
  localparam logic [6:0]  ADDR_SOT_B  = 7'h21;
  localparam logic [6:0]  ADDR_SOT_C  = 7'h22;
  localparam logic [6:0]  SYNC_ADDR   = 7'h7E;
  localparam int          CMD_SY      = 0;
  localparam int          CMD_SD      = 1;
  localparam int          CMD_BG      = 2;
  localparam logic [3:0]  CNT_ACK     = 4'h8;
  localparam logic [3:0]  CNT_DONE    = 4'h9;
  localparam logic [7:0]  CMD_RESET   = 8'h00;
  localparam logic [9:0]  CODE_RESET  = 10'h000;
  localparam int          SI_SCL      = 0;
  localparam int          SI_SDA      = 1;
  localparam int          SI_TGL      = 2;
  localparam int          SI_AD0      = 3;
  localparam int          SI_AD1      = 4;
  localparam int          SI_AD2      = 5;
  localparam int          SI_W        = 6;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_CMD  = 3'h2,
    ST_LO   = 3'h3,
    ST_HI   = 3'h4,
    ST_SKIP = 3'h5
  } sdw_state_t;

  typedef enum logic [2:0] {
    VAR_MSOP_STD = 3'h0,
    VAR_MSOP_ALT = 3'h1,
    VAR_SOT_A    = 3'h2,
    VAR_SOT_B    = 3'h3,
    VAR_SOT_C    = 3'h4
  } sdw_variant_t;
endpackage : sdw_pkg

// >>> src/sdw_slave.sv
// Receive-only SMBus slave front end of a 10-bit DAC.
// Assumes an open-drain SDA resolved outside and SCL wired to scl_clk.
`timescale 1ns/10ps
module sdw_slave #(
  parameter sdw_pkg::sdw_variant_t VARIANT = sdw_pkg::VAR_MSOP_STD
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst_n,
  input  wire logic                        scl_clk,
  input  wire logic                        sda_in,
  input  wire logic                        address_select_pin_two,
  input  wire logic                        address_select_pin_one,
  input  wire logic                        address_select_pin_zero,
  output logic                             sda_out,
  output logic                             sda_oe_n,
  output logic [sdw_pkg::CODE_W-1:0]       dac_code,
  output logic                             dac_shutdown,
  output logic                             dac_bandgap_sel
);
  import sdw_pkg::*;

  // Link side: SDA is sampled on the exact rising SCL edge and a toggle
  // tells the core a new bit stands; the bit is stable for a whole clock.
  logic link_bit_q, link_bit_d, link_tgl_q, link_tgl_d;

  always_comb begin
    link_bit_d = sda_in;
    link_tgl_d = ~link_tgl_q;
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_bit_q <= 1'b0;
      link_tgl_q <= 1'b0;
    end else begin
      link_bit_q <= link_bit_d;
      link_tgl_q <= link_tgl_d;
    end
  end

  // Two-stage synchronisers; only the second stage and its history are
  // used, so START and STOP detection never sees a metastable value.
  logic [SI_W-1:0] sync_m_q, sync_m_d, sync_s_q, sync_s_d;
  logic [2:0]      hist_q, hist_d;

  always_comb begin
    sync_m_d = {address_select_pin_two, address_select_pin_one,
                address_select_pin_zero, link_tgl_q, sda_in, scl_clk};
    sync_s_d = sync_m_q;
    hist_d   = sync_s_q[2:0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_m_q <= '0;
      sync_s_q <= '0;
      hist_q   <= '0;
    end else begin
      sync_m_q <= sync_m_d;
      sync_s_q <= sync_s_d;
      hist_q   <= hist_d;
    end
  end

  logic       start_ev, stop_ev, fall_ev, bit_ev;
  logic [6:0] own_addr;

  always_comb begin
    start_ev = sync_s_q[SI_SCL] && hist_q[SI_SCL] &&
               hist_q[SI_SDA] && !sync_s_q[SI_SDA];
    stop_ev  = sync_s_q[SI_SCL] && hist_q[SI_SCL] &&
               !hist_q[SI_SDA] && sync_s_q[SI_SDA];
    fall_ev  = hist_q[SI_SCL] && !sync_s_q[SI_SCL];
    bit_ev   = sync_s_q[SI_TGL] ^ hist_q[SI_TGL];
    case (VARIANT)
      VAR_MSOP_STD:
        own_addr = {PREFIX_STD, sync_s_q[SI_AD2:SI_AD0]};
      VAR_MSOP_ALT: own_addr = {PREFIX_ALT, sync_s_q[SI_AD2:SI_AD0]};
      VAR_SOT_A:    own_addr = ADDR_SOT_A;
      VAR_SOT_B:    own_addr = ADDR_SOT_B;
      VAR_SOT_C:    own_addr = ADDR_SOT_C;
      default:      own_addr = {PREFIX_STD, sync_s_q[SI_AD2:SI_AD0]};
    endcase
  end

  // Protocol engine.
  sdw_state_t        state_q, state_d;
  logic [3:0]        cnt_q, cnt_d;
  logic [7:0]        shift_q, shift_d;
  logic              drive_q, drive_d;
  logic [7:0]        command_input_q, command_input_d;
  logic [7:0]        lo_pend_q, lo_pend_d;
  logic [CODE_W-1:0] code_in_q, code_in_d;
  logic [CODE_W-1:0] code_out_q, code_out_d;
  logic              shut_q, shut_d;
  logic              bg_q, bg_d;
  logic              is_sync, ack_ok, ack_rise;

  always_comb begin
    is_sync  = (shift_q[7:1] == SYNC_ADDR);
    // A read to the own address is not acknowledged: no read data exists.
    ack_ok   = ((state_q == ST_ADDR) &&
                (is_sync || (shift_q[7:1] == own_addr && !shift_q[0]))) ||
               (state_q == ST_CMD) || (state_q == ST_LO) ||
               (state_q == ST_HI);
    ack_rise = bit_ev && (cnt_q == CNT_ACK) && (state_q != ST_IDLE);
  end

  always_comb begin
    state_d         = state_q;
    cnt_d           = cnt_q;
    shift_d         = shift_q;
    drive_d         = drive_q;
    command_input_d = command_input_q;
    lo_pend_d       = lo_pend_q;
    code_in_d       = code_in_q;
    code_out_d      = code_out_q;
    shut_d          = shut_q;
    bg_d            = bg_q;
    if (bit_ev && state_q != ST_IDLE && cnt_q < CNT_ACK) begin
      shift_d = {shift_q[6:0], link_bit_q};
      cnt_d   = cnt_q + 4'h1;
    end
    if (ack_rise) begin
      cnt_d   = CNT_DONE;
      state_d = ST_SKIP;
      case (state_q)
        ST_ADDR: begin
          if (ack_ok && is_sync) begin
            if (!shift_q[0]) begin
              command_input_d = CMD_RESET;
              lo_pend_d       = 8'h00;
              code_in_d       = CODE_RESET;
              code_out_d      = CODE_RESET;
              shut_d          = 1'b0;
              bg_d            = 1'b0;
            end else if (command_input_q[CMD_SY]) begin
              code_out_d = code_in_q;
              bg_d       = command_input_q[CMD_BG];
            end
          end else if (ack_ok) begin
            state_d = ST_CMD;
          end
        end
        ST_CMD: begin
          command_input_d = shift_q;
          state_d         = ST_LO;
        end
        ST_LO: begin
          lo_pend_d = shift_q;
          state_d   = ST_HI;
        end
        ST_HI: begin
          // Data commits only here, so an interrupted word leaves it alone.
          code_in_d = {shift_q[1:0], lo_pend_q};
        end
        default: begin
          state_d = ST_SKIP;
        end
      endcase
    end
    if (fall_ev) begin
      if (cnt_q == CNT_ACK && ack_ok) begin
        drive_d = 1'b1;
      end else if (cnt_q == CNT_DONE) begin
        drive_d = 1'b0;
        cnt_d   = 4'h0;
      end
    end
    if (start_ev) begin
      state_d = ST_ADDR;
      cnt_d   = 4'h0;
      drive_d = 1'b0;
    end
    if (stop_ev) begin
      state_d = ST_IDLE;
      cnt_d   = 4'h0;
      drive_d = 1'b0;
      shut_d  = command_input_q[CMD_SD];
      if (!command_input_q[CMD_SY]) begin
        code_out_d = code_in_q;
        bg_d       = command_input_q[CMD_BG];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q         <= ST_IDLE;
      cnt_q           <= 4'h0;
      shift_q         <= 8'h00;
      drive_q         <= 1'b0;
      command_input_q <= CMD_RESET;
      lo_pend_q       <= 8'h00;
      code_in_q       <= CODE_RESET;
      code_out_q      <= CODE_RESET;
      shut_q          <= 1'b0;
      bg_q            <= 1'b0;
    end else begin
      state_q         <= state_d;
      cnt_q           <= cnt_d;
      shift_q         <= shift_d;
      drive_q         <= drive_d;
      command_input_q <= command_input_d;
      lo_pend_q       <= lo_pend_d;
      code_in_q       <= code_in_d;
      code_out_q      <= code_out_d;
      shut_q          <= shut_d;
      bg_q            <= bg_d;
    end
  end

  // The pin only ever pulls low; the pull-up supplies every high level.
  assign sda_out         = 1'b0;
  assign sda_oe_n        = ~drive_q;
  assign dac_code        = code_out_q;
  assign dac_shutdown    = shut_q;
  assign dac_bandgap_sel = bg_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_ack_hold;
    (drive_q && sync_s_q[SI_SCL] && hist_q[SI_SCL]) |=> drive_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("Acknowledge released while SCL high.");

  property p_start;
    start_ev && !stop_ev |=> state_q == ST_ADDR && cnt_q == 4'h0;
  endproperty
  a_start: assert property (p_start)
    else $error("START did not restart address phase.");

  property p_stop;
    stop_ev |=> state_q == ST_IDLE && !drive_q;
  endproperty
  a_stop: assert property (p_stop)
    else $error("STOP did not free the slave.");

  property p_stop_update;
    stop_ev && !command_input_q[CMD_SY] |=> dac_code == $past(code_in_q);
  endproperty
  a_stop_update: assert property (p_stop_update)
    else $error("STOP did not update the output code.");

  property p_sync_hold;
    stop_ev && command_input_q[CMD_SY] |=> $stable(dac_code);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("Output code changed on STOP in sync mode.");

  property p_cmd_latch;
    ack_rise && state_q == ST_CMD |=> command_input_q == $past(shift_q);
  endproperty
  a_cmd_latch: assert property (p_cmd_latch)
    else $error("Command byte not latched on acknowledge.");

  property p_no_ack;
    fall_ev && cnt_q == CNT_ACK && !ack_ok |=> !drive_q [*2];
  endproperty
  a_no_ack: assert property (p_no_ack)
    else $error("Acknowledged a byte that must be ignored.");

  property p_shutdown;
    stop_ev |=> dac_shutdown == $past(command_input_q[CMD_SD]);
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Shutdown bit not applied at STOP.");

  property p_sync_clear;
    ack_rise && state_q == ST_ADDR && is_sync && !shift_q[0] && !stop_ev
      |=> dac_code == CODE_RESET && command_input_q == CMD_RESET;
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("Sync write quick command did not clear.");
endmodule : sdw_slave

// >>> verification/sdw_host.sv
// Behavioural SMBus host that drives SCL and SDA for the DAC write slave.
// Assumes the bench resolves the open-drain SDA wire and feeds it back.
`timescale 1ns/10ps
module sdw_host (
  output logic scl,
  output logic sda_m,
  input  wire logic sda_wire
);
  // Each SCL phase is far longer than the slave's synchroniser delay.
  localparam int H = 1024;

  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // Also serves as a repeated START: SCL rises with SDA high first.
  task automatic start();
    #(H/2) sda_m = 1'b1;
    #(H/2) scl = 1'b1;
    #(H) sda_m = 1'b0;
    #(H) scl = 1'b0;
  endtask : start

  task automatic bit_out(input logic b);
    #(H/2) sda_m = b;
    #(H/2) scl = 1'b1;
    #(H) scl = 1'b0;
  endtask : bit_out

  // Sends eight bits MSB first, then clocks the acknowledge with SDA free.
  task automatic send(input logic [7:0] v, output logic ack);
    logic a0;
    for (int i = 7; i >= 0; i--) bit_out(v[i]);
    #(H/2) sda_m = 1'b1;
    #(H/2) scl = 1'b1;
    #1 a0 = sda_wire;
    #(H-1) ack = !a0 && !sda_wire;
    scl = 1'b0;
  endtask : send

  task automatic stop();
    #(H/2) sda_m = 1'b0;
    #(H/2) scl = 1'b1;
    #(H) sda_m = 1'b1;
    #(H);
  endtask : stop
endmodule : sdw_host

// >>> verification/smbus_dac_write_slave_test.sv
// Self-checking bench for the DAC write slave with a host model.
// Assumes the standard eight-pin build with strap pins.
`timescale 1ns/10ps
module smbus_dac_write_slave_test;
  import sdw_pkg::*;
  logic              core_clk;
  logic              rst_n;
  logic [2:0]        strap;
  logic              scl;
  logic              sda_m;
  wire logic         sda_wire;
  logic              sda_out;
  logic              sda_oe_n;
  logic [CODE_W-1:0] dac_code;
  logic              dac_shutdown;
  logic              dac_bandgap_sel;
  logic              alt_oe_n;
  logic              sot_oe_n;
  logic [CODE_W-1:0] alt_code;
  logic [CODE_W-1:0] sot_code;
  logic              ack;
  int                bad_count;
  int                compares;
  typedef struct {
    logic [2:0] pins; logic [6:0] adr; logic [7:0] cmd; logic [7:0] lo;
    logic [7:0] hi; logic ack; logic [11:0] out;
  } sdw_row_t;
  sdw_row_t rows [5] = '{
    '{3'h5, 7'h25, 8'h04, 8'hAB, 8'hFE, 1'b1, 12'h6AB},
    '{3'h0, 7'h20, 8'h00, 8'h00, 8'h03, 1'b1, 12'h300},
    '{3'h7, 7'h27, 8'h02, 8'h55, 8'h01, 1'b1, 12'h955},
    '{3'h7, 7'h26, 8'h00, 8'h00, 8'h00, 1'b0, 12'h955},
    '{3'h7, 7'h27, 8'h00, 8'h00, 8'h00, 1'b1, 12'h000}
  };

  // The slave only pulls low; a released wire rests at the pull-up level.
  assign sda_wire = sda_m & (sda_oe_n | sda_out) & alt_oe_n & sot_oe_n;

  sdw_host u_sdw_host (.scl(scl), .sda_m(sda_m), .sda_wire(sda_wire));

  sdw_slave #(.VARIANT(VAR_MSOP_STD)) u_sdw_slave (
    .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_wire),
    .address_select_pin_two(strap[2]), .address_select_pin_one(strap[1]),
    .address_select_pin_zero(strap[0]), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .dac_code(dac_code),
    .dac_shutdown(dac_shutdown), .dac_bandgap_sel(dac_bandgap_sel)
  );

  // Other builds share the bus; of their addresses the main slave uses 7'h21, with strap 3'h1, and the sync address 7'h7E.
  sdw_slave #(.VARIANT(VAR_MSOP_ALT)) u_sdw_slave_alt (
    .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_wire),
    .address_select_pin_two(strap[2]), .address_select_pin_one(strap[1]),
    .address_select_pin_zero(strap[0]), .sda_out(),
    .sda_oe_n(alt_oe_n), .dac_code(alt_code),
    .dac_shutdown(), .dac_bandgap_sel()
  );

  sdw_slave #(.VARIANT(VAR_SOT_B)) u_sdw_slave_sot (
    .core_clk(core_clk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda_wire),
    .address_select_pin_two(strap[2]), .address_select_pin_one(strap[1]),
    .address_select_pin_zero(strap[0]), .sda_out(),
    .sda_oe_n(sot_oe_n), .dac_code(sot_code),
    .dac_shutdown(), .dac_bandgap_sel()
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  function automatic logic [11:0] outs();
    return {dac_shutdown, dac_bandgap_sel, dac_code};
  endfunction : outs

  // Sends address then n bytes and a STOP; ack keeps the AND of all acks.
  task automatic word(input logic [7:0] a, input logic [7:0] c,
                      input logic [7:0] l, input logic [7:0] h, input int n);
    logic k;
    u_sdw_host.start();
    u_sdw_host.send(a, ack);
    if (n > 0) begin
      u_sdw_host.send(c, k);
      ack = ack & k;
    end
    if (n > 1) begin
      u_sdw_host.send(l, k);
      ack = ack & k;
    end
    if (n > 2) begin
      u_sdw_host.send(h, k);
      ack = ack & k;
    end
    u_sdw_host.stop();
    repeat (10) @(posedge core_clk);
  endtask : word

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #3ms;
    bad_count++;
    report_and_stop();
  end

  initial begin
    bad_count = 0;
    compares  = 0;
    rst_n     = 1'b0;
    strap     = 3'h0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check({sda_oe_n, 11'h000}, {1'b1, 11'h000});
    check(outs(), 12'h000);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge core_clk);
      strap <= rows[i].pins;
      repeat (6) @(posedge core_clk);
      word({rows[i].adr, 1'b0}, rows[i].cmd, rows[i].lo, rows[i].hi, 3);
      check(12'(ack), 12'(rows[i].ack));
      check(outs(), rows[i].out);
    end
    $display("test rows done");
    word({7'h1F, 1'b0}, 8'h00, 8'h12, 8'h01, 3);
    check(12'(ack), 12'h001);
    check({2'b00, alt_code}, 12'h112);
    word({7'h21, 1'b0}, 8'h00, 8'h34, 8'h02, 3);
    check(12'(ack), 12'h001);
    check({2'b00, sot_code}, 12'h234);
    check(outs(), 12'h000);
    $display("test variants done");
    word({7'h27, 1'b1}, 8'h00, 8'h00, 8'h00, 0);
    check({11'h000, ack}, 12'h000);
    word({7'h27, 1'b0}, 8'h05, 8'h11, 8'h02, 3);
    check(outs(), 12'h000);
    word({SYNC_ADDR, 1'b1}, 8'h00, 8'h00, 8'h00, 0);
    check(12'(ack), 12'h001);
    check(outs(), 12'h611);
    word({7'h27, 1'b0}, 8'h01, 8'h33, 8'h00, 2);
    check(outs(), 12'h611);
    word({SYNC_ADDR, 1'b1}, 8'h00, 8'h00, 8'h00, 0);
    check(outs(), 12'h211);
    word({SYNC_ADDR, 1'b0}, 8'h00, 8'h00, 8'h00, 0);
    check(outs(), 12'h000);
    $display("test sync done");
    u_sdw_host.start();
    u_sdw_host.send({7'h27, 1'b0}, ack);
    repeat (3) u_sdw_host.bit_out(1'b1);
    u_sdw_host.start();
    u_sdw_host.send({7'h27, 1'b0}, ack);
    u_sdw_host.stop();
    repeat (10) @(posedge core_clk);
    check(12'(ack), 12'h001);
    check(outs(), 12'h000);
    $display("test cut command done");
    u_sdw_host.start();
    u_sdw_host.send({7'h27, 1'b0}, ack);
    u_sdw_host.send(8'h06, ack);
    u_sdw_host.send(8'h7F, ack);
    u_sdw_host.send(8'h02, ack);
    u_sdw_host.start();
    check(outs(), 12'h000);
    u_sdw_host.send({7'h26, 1'b0}, ack);
    u_sdw_host.stop();
    repeat (10) @(posedge core_clk);
    check(12'(ack), 12'h000);
    check(outs(), 12'hE7F);
    $display("test chain done");
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    check(outs(), 12'h000);
    rst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    check(outs(), 12'h000);
    word({7'h27, 1'b0}, 8'h00, 8'h01, 8'h00, 3);
    check(outs(), 12'h001);
    $display("test reset again done");
    report_and_stop();
  end
endmodule : smbus_dac_write_slave_test
